/* verilog/fgs_status_top.sv */
/*
  Gateway status and supervision: reader polling cadence, code
  indicators, error latching and warning timeout, diagnostic byte,
  fieldbus indicators and station address capture.
  Assumes fault events are one-cycle pulses on clk; selectors are pins.
*/
`timescale 1ns/10ps
`default_nettype none
module fgs_status_top
  import fgs_pkg::*;
#(
  parameter longint unsigned WARN_CYCLES  = WARN_HOLD_CYCLES,
  parameter int unsigned FLASH_CYCLES = FLASH_HALF_CYCLES
)
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [3:0] reader_present,
  input  wire logic [3:0] address_upper_selector,
  input  wire logic [3:0] address_lower_selector,
  input  wire logic [3:0] spare_selector_a,
  input  wire logic [3:0] spare_selector_b,
  input  wire logic       err_hw,
  input  wire logic       err_nvm,
  input  wire logic       err_intmem,
  input  wire logic       err_fieldbus,
  input  wire logic       err_script,
  input  wire logic       warn_rs_tx_ovf,
  input  wire logic       warn_rs_rx_ovf,
  input  wire logic       warn_rs_timeout,
  input  wire logic       warn_fb_general,
  input  wire logic       warn_fb_parity,
  input  wire logic       warn_fb_config,
  input  wire logic       warn_fb_ovf,
  input  wire logic [1:0] fb_state,
  output logic            poll_strobe,
  output logic [1:0]      poll_addr,
  output logic            data_exchange_enable,
  output logic [7:0]      station_address,
  output logic            station_address_valid,
  output logic [1:0]      module_state_indicator,
  output logic            code_indicator_bit0,
  output logic            code_indicator_bit1,
  output logic            code_indicator_bit2,
  output logic            code_indicator_bit3,
  output logic [7:0]      ext_diag_byte,
  output logic [1:0]      fieldbus_state_indicator,
  output logic            fieldbus_fault_indicator
);

  localparam int unsigned WW = $clog2(WARN_CYCLES + 1);
  localparam int unsigned FW = $clog2(FLASH_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [15:0] sel_meta_reg;
  logic [15:0] sel_sync_reg;

  always_ff @(posedge clk) begin
    sel_meta_reg <= {address_upper_selector, address_lower_selector,
                     spare_selector_a, spare_selector_b};
    sel_sync_reg <= sel_meta_reg;
  end

  ////////////////////////////////////////////////////////////////////////
  // Station address capture, three cycles after reset release

  logic [1:0] cap_cnt_reg;
  logic [7:0] addr_reg;
  logic       addr_valid_reg;
  logic       spare_ok_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      cap_cnt_reg    <= 2'h0;
      addr_reg       <= ADDR_RESET;
      addr_valid_reg <= 1'b0;
    end else if (!addr_valid_reg) begin
      cap_cnt_reg <= cap_cnt_reg + 2'h1;
      if (cap_cnt_reg == 2'h2) begin
        addr_reg       <= sel_sync_reg[15:8];
        addr_valid_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      spare_ok_reg <= 1'b0;
    end else begin
      spare_ok_reg <= (sel_sync_reg[7:4] == SPARE_REQUIRED) &&
                      (sel_sync_reg[3:0] == SPARE_REQUIRED);
    end
  end

  assign station_address       = addr_reg;
  assign station_address_valid = addr_valid_reg;
  assign data_exchange_enable  = spare_ok_reg && addr_valid_reg;

  ////////////////////////////////////////////////////////////////////////
  // Polling

  fgs_poll_sched u_sched (
    .clk            (clk),
    .srst           (srst),
    .enable         (data_exchange_enable),
    .reader_present (reader_present),
    .poll_strobe    (poll_strobe),
    .poll_addr      (poll_addr)
  );

  ////////////////////////////////////////////////////////////////////////
  // Event coding

  function automatic logic [3:0] fgs_err_code(input logic [4:0] ev);
    logic [3:0] c;
    c = CODE_NONE;
    if (ev[4]) c = CODE_SCRIPT;
    if (ev[3]) c = CODE_FB_HW;
    if (ev[2]) c = CODE_INTMEM;
    if (ev[1]) c = CODE_NVM;
    if (ev[0]) c = CODE_HW;
    return c;
  endfunction : fgs_err_code

  function automatic logic [3:0] fgs_warn_code(input logic [6:0] ev);
    logic [3:0] c;
    c = CODE_NONE;
    if (ev[6]) c = CODE_FB_OVF;
    if (ev[5]) c = CODE_FB_CONFIG;
    if (ev[4]) c = CODE_FB_PARITY;
    if (ev[3]) c = CODE_FB_GENERAL;
    if (ev[2]) c = CODE_RS_TIMEOUT;
    if (ev[1]) c = CODE_RS_RX_OVF;
    if (ev[0]) c = CODE_RS_TX_OVF;
    return c;
  endfunction : fgs_warn_code

  logic [3:0] err_in;
  logic [3:0] warn_in;

  assign err_in  = fgs_err_code({err_script, err_fieldbus, err_intmem,
                                 err_nvm, err_hw});
  assign warn_in = fgs_warn_code({warn_fb_ovf, warn_fb_config,
                                  warn_fb_parity, warn_fb_general,
                                  warn_rs_timeout, warn_rs_rx_ovf,
                                  warn_rs_tx_ovf});

  ////////////////////////////////////////////////////////////////////////
  // Error latch and warning timer

  logic [3:0]    err_code_reg;
  logic [3:0]    warn_code_reg;
  logic [WW-1:0] warn_cnt_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      err_code_reg <= CODE_NONE;
    end else if (err_code_reg == CODE_NONE && err_in != CODE_NONE) begin
      err_code_reg <= err_in;
    end
  end

  // A new warning restarts the minute; expiry clears it
  always_ff @(posedge clk) begin
    if (srst) begin
      warn_code_reg <= CODE_NONE;
      warn_cnt_reg  <= '0;
    end else if (warn_in != CODE_NONE) begin
      warn_code_reg <= warn_in;
      warn_cnt_reg  <= WW'(WARN_CYCLES - 1);
    end else if (warn_code_reg != CODE_NONE) begin
      if (warn_cnt_reg == '0) begin
        warn_code_reg <= CODE_NONE;
      end else begin
        warn_cnt_reg <= warn_cnt_reg - WW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Module state and code indicators

  logic [3:0] shown_code;
  logic [3:0] code_reg;
  logic [1:0] mod_led_reg;

  assign shown_code = (err_code_reg != CODE_NONE) ? err_code_reg
                                                  : warn_code_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      code_reg    <= 4'h0;
      mod_led_reg <= FGS_LED_OFF;
    end else if (shown_code != CODE_NONE) begin
      code_reg    <= shown_code;
      mod_led_reg <= FGS_LED_RED;
    end else if (data_exchange_enable) begin
      code_reg    <= 4'h1 << poll_addr;
      mod_led_reg <= FGS_LED_GREEN;
    end else begin
      code_reg    <= 4'h0;
      mod_led_reg <= FGS_LED_OFF;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ext_diag_byte <= 8'h00;
    end else begin
      ext_diag_byte <= {4'h0, shown_code};
    end
  end

  assign module_state_indicator = mod_led_reg;
  assign code_indicator_bit0    = code_reg[0];
  assign code_indicator_bit1    = code_reg[1];
  assign code_indicator_bit2    = code_reg[2];
  assign code_indicator_bit3    = code_reg[3];

  ////////////////////////////////////////////////////////////////////////
  // Fieldbus indicators

  logic [FW-1:0] flash_cnt_reg;
  logic          flash_phase_reg;
  logic [1:0]    fb_led_reg;
  logic          fb_fault_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      flash_cnt_reg   <= '0;
      flash_phase_reg <= 1'b0;
    end else if (flash_cnt_reg == FW'(FLASH_CYCLES - 1)) begin
      flash_cnt_reg   <= '0;
      flash_phase_reg <= !flash_phase_reg;
    end else begin
      flash_cnt_reg <= flash_cnt_reg + FW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fb_led_reg   <= FGS_LED_OFF;
      fb_fault_reg <= 1'b1;
    end else begin
      fb_fault_reg <= (fb_state != FGS_FB_DATA_EX);
      case (fb_state)
        FGS_FB_DATA_EX:  fb_led_reg <= FGS_LED_GREEN;
        FGS_FB_WAIT_PRM: fb_led_reg <= flash_phase_reg ? FGS_LED_RED
                                                       : FGS_LED_GREEN;
        FGS_FB_WAIT_CFG: fb_led_reg <= flash_phase_reg ? FGS_LED_OFF
                                                       : FGS_LED_GREEN;
        FGS_FB_ERROR:    fb_led_reg <= FGS_LED_RED;
        default:         fb_led_reg <= FGS_LED_RED;
      endcase
    end
  end

  assign fieldbus_state_indicator = fb_led_reg;
  assign fieldbus_fault_indicator = fb_fault_reg;

endmodule : fgs_status_top
`default_nettype wire

/* verilog/fgs_pkg.sv */
/*
  Constants and types shared by the gateway status logic.
  Assumes a 100 MHz system clock.
*/
package fgs_pkg;

  localparam int unsigned CLK_HZ            = 100_000_000;
  localparam int unsigned POLL_PERIOD_US    = 1000;
  // Per-reader refresh of about 1 ms when all four readers are present, split over four slots
  localparam int unsigned POLL_SLOT_CYCLES  =
    (CLK_HZ / 1_000_000) * POLL_PERIOD_US / 4;
  localparam int unsigned WARN_HOLD_S       = 60;
  // One minute of cycles does not fit 32 bits, so it is held in 64
  localparam longint unsigned WARN_HOLD_CYCLES =
    64'(CLK_HZ) * 64'(WARN_HOLD_S);
  localparam int unsigned FLASH_HALF_MS     = 250;
  localparam int unsigned FLASH_HALF_CYCLES =
    (CLK_HZ / 1000) * FLASH_HALF_MS;
  localparam int unsigned MAX_BAUD          = 12_000_000;

  localparam logic [3:0] CODE_NONE        = 4'h0;
  localparam logic [3:0] CODE_HW          = 4'h1;
  localparam logic [3:0] CODE_NVM         = 4'h2;
  localparam logic [3:0] CODE_INTMEM      = 4'h3;
  localparam logic [3:0] CODE_FB_HW       = 4'h4;
  localparam logic [3:0] CODE_SCRIPT      = 4'h5;
  localparam logic [3:0] CODE_LAST_ERROR  = 4'h5;
  localparam logic [3:0] CODE_RS_TX_OVF   = 4'h7;
  localparam logic [3:0] CODE_RS_RX_OVF   = 4'h8;
  localparam logic [3:0] CODE_RS_TIMEOUT  = 4'h9;
  localparam logic [3:0] CODE_FB_GENERAL  = 4'hA;
  localparam logic [3:0] CODE_FB_PARITY   = 4'hB;
  localparam logic [3:0] CODE_FB_CONFIG   = 4'hD;
  localparam logic [3:0] CODE_FB_OVF      = 4'hE;

  localparam logic [3:0] SPARE_REQUIRED   = 4'h0;
  localparam logic [7:0] ADDR_RESET       = 8'h00;

  // Fieldbus link state reported by the protocol engine
  typedef enum logic [1:0] {
    FGS_FB_WAIT_PRM = 2'b00,
    FGS_FB_WAIT_CFG = 2'b01,
    FGS_FB_DATA_EX  = 2'b11,
    FGS_FB_ERROR    = 2'b10
  } fgs_fb_state_t;

  // Two-colour indicator drive
  typedef enum logic [1:0] {
    FGS_LED_OFF   = 2'b00,
    FGS_LED_GREEN = 2'b01,
    FGS_LED_RED   = 2'b10
  } fgs_led_t;

endpackage : fgs_pkg

/* verilog/fgs_poll_sched.sv */
/*
  Reader polling scheduler: steps round-robin through present readers.
  Assumes reader_present is stable logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module fgs_poll_sched
  import fgs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       enable,
  input  wire logic [3:0] reader_present,
  output logic            poll_strobe,
  output logic [1:0]      poll_addr
);

  localparam int unsigned CW = $clog2(POLL_SLOT_CYCLES);

  logic [CW-1:0] slot_cnt_reg;
  logic [1:0]    addr_reg;
  logic          strobe_reg;
  logic [1:0]    addr_next;
  logic          slot_end;

  assign slot_end = (slot_cnt_reg == CW'(POLL_SLOT_CYCLES - 1));

  // Next present address above the current one, wrapping
  always_comb begin
    addr_next = addr_reg;
    for (int i = 3; i >= 1; i--) begin
      if (reader_present[2'(addr_reg + 2'(i))]) begin
        addr_next = 2'(addr_reg + 2'(i));
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !enable || slot_end) begin
      slot_cnt_reg <= '0;
    end else begin
      slot_cnt_reg <= slot_cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      addr_reg   <= 2'h0;
      strobe_reg <= 1'b0;
    end else begin
      strobe_reg <= enable && slot_end && (reader_present != 4'h0);
      if (enable && slot_end) begin
        addr_reg <= addr_next;
      end
    end
  end

  assign poll_strobe = strobe_reg;
  assign poll_addr   = addr_reg;

endmodule : fgs_poll_sched
`default_nettype wire

/* tb/fgs_status_assertions.sv */
/*
  Port-level checks of the gateway status block.
  Assumes it is bound to fgs_status_top, one clock, srst high.
*/
`timescale 1ns/10ps
`default_nettype none
module fgs_status_chk
  import fgs_pkg::*;
#(
  parameter longint unsigned WARN_CYCLES  = 200,
  parameter int unsigned FLASH_CYCLES = 8
)
(
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [3:0] reader_present,
  input wire logic       err_hw,
  input wire logic [1:0] fb_state,
  input wire logic       poll_strobe,
  input wire logic [1:0] poll_addr,
  input wire logic       data_exchange_enable,
  input wire logic [7:0] station_address,
  input wire logic       station_address_valid,
  input wire logic [1:0] module_state_indicator,
  input wire logic       code_indicator_bit0,
  input wire logic       code_indicator_bit1,
  input wire logic       code_indicator_bit2,
  input wire logic       code_indicator_bit3,
  input wire logic [7:0] ext_diag_byte,
  input wire logic [1:0] fieldbus_state_indicator,
  input wire logic       fieldbus_fault_indicator
);
  ////////////////////////////////////////////////////////////////////////
  logic [3:0]  code;
  int unsigned gap_reg;
  logic        seen_reg;
  assign code = {code_indicator_bit3, code_indicator_bit2,
                 code_indicator_bit1, code_indicator_bit0};
  // Cycles since the last poll strobe
  always_ff @(posedge clk) begin
    gap_reg <= poll_strobe ? 32'h0 : gap_reg + 32'h1;
  end
  always_ff @(posedge clk) begin
    seen_reg <= !srst && data_exchange_enable && (seen_reg || poll_strobe);
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  a_fault_lit: assert property (fb_state != 2'h3 |=> fieldbus_fault_indicator)
    else $error("fault indicator dark without data exchange");
  a_fault_dark: assert property (fb_state == 2'h3 |=> !fieldbus_fault_indicator)
    else $error("fault indicator lit during data exchange");
  a_fb_green: assert property (fb_state == 2'h3 |=> fieldbus_state_indicator == 2'h1)
    else $error("bus state not green in data exchange");
  a_fb_red: assert property (fb_state == 2'h2 |=> fieldbus_state_indicator == 2'h2)
    else $error("bus state not red on bus error");
  a_err_shows: assert property (err_hw |-> ##2 module_state_indicator == 2'h2)
    else $error("error not shown red two cycles on");
  a_err_held: assert property (module_state_indicator == 2'h2 && code inside {[4'h1:4'h5]} |=> module_state_indicator == 2'h2 && $stable(code))
    else $error("latched error changed");
  a_diag_code: assert property (module_state_indicator == 2'h2 |-> ext_diag_byte == {4'h0, code})
    else $error("diagnostic byte differs from shown code");
  a_poll_onehot: assert property (module_state_indicator == 2'h1 && $past(module_state_indicator) == 2'h1 && $stable(poll_addr) |-> code == 4'h1 << poll_addr)
    else $error("code indicators not one-hot of polled address");
  a_strobe_pulse: assert property (poll_strobe |=> !poll_strobe)
    else $error("poll strobe longer than one cycle");
  a_strobe_present: assert property (poll_strobe |-> reader_present[poll_addr])
    else $error("absent reader polled");
  a_strobe_gap: assert property (poll_strobe && seen_reg |-> gap_reg == POLL_SLOT_CYCLES - 1)
    else $error("poll slot length wrong");
  a_addr_hold: assert property ($past(station_address_valid) |-> station_address_valid && $stable(station_address))
    else $error("station address changed after capture");
endmodule : fgs_status_chk
bind fgs_status_top fgs_status_chk #(.WARN_CYCLES(WARN_CYCLES),
  .FLASH_CYCLES(FLASH_CYCLES)) i_chk (.clk(clk), .srst(srst),
  .reader_present(reader_present), .err_hw(err_hw), .fb_state(fb_state),
  .poll_strobe(poll_strobe), .poll_addr(poll_addr),
  .data_exchange_enable(data_exchange_enable),
  .station_address(station_address),
  .station_address_valid(station_address_valid),
  .module_state_indicator(module_state_indicator),
  .code_indicator_bit0(code_indicator_bit0),
  .code_indicator_bit1(code_indicator_bit1),
  .code_indicator_bit2(code_indicator_bit2),
  .code_indicator_bit3(code_indicator_bit3),
  .ext_diag_byte(ext_diag_byte),
  .fieldbus_state_indicator(fieldbus_state_indicator),
  .fieldbus_fault_indicator(fieldbus_fault_indicator));
`default_nettype wire

/* tb/fgs_field_model.sv */
/*
  Far side model: readers on the link and the spare selectors.
  Assumes the bench chooses fitted addresses and any misadjustment.
*/
`timescale 1ns/10ps
`default_nettype none
module fgs_field_model (
  input  wire logic [3:0] fitted,
  input  wire logic [3:0] misset,
  output logic      [3:0] reader_present,
  output logic      [3:0] spare_selector_a,
  output logic      [3:0] spare_selector_b
);
  // One bit per address, so no two readers can share one
  assign reader_present   = fitted;
  assign spare_selector_a = misset;
  assign spare_selector_b = 4'h0;
endmodule : fgs_field_model
`default_nettype wire

/* tb/tb_top.sv */
/*
  Self-checking bench of the gateway status block.
  Assumes short warning and flash counts set by parameter.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_top;
  import fgs_pkg::*;
  localparam int unsigned WARN  = 200;
  localparam int unsigned LIMIT = 95000;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [11:0] ev = 12'h0;
  logic [3:0]  hi = 4'h0, lo = 4'h0, fitted = 4'hB, misset = 4'h0;
  logic [1:0]  fb_state = 2'h3;
  logic [3:0]  reader_present, spare_selector_a, spare_selector_b;
  logic        poll_strobe, data_exchange_enable, station_address_valid;
  logic [1:0]  poll_addr, module_state_indicator, fieldbus_state_indicator;
  logic [7:0]  station_address, ext_diag_byte, prev_diag = 8'h0;
  logic        code_indicator_bit0, code_indicator_bit1;
  logic        code_indicator_bit2, code_indicator_bit3;
  logic        fieldbus_fault_indicator;
  logic [3:0]  code, seen;
  logic [9:0]  evq[$];
  logic [1:0]  pq[$];
  logic [1:0]  poll_exp;
  logic [9:0]  diag_exp;
  logic [3:0]  codes[12] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8,
                             4'h9, 4'hA, 4'hB, 4'hD, 4'hE};
  logic [5:0]  fbt[4] = '{6'h32, 6'h24, 6'h06, 6'h13};
  int          errors = 0, n_checks = 0, cyc_cnt = 0;
  assign code = {code_indicator_bit3, code_indicator_bit2,
                 code_indicator_bit1, code_indicator_bit0};
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  fgs_field_model i_field (.fitted, .misset, .reader_present,
    .spare_selector_a, .spare_selector_b);
  fgs_status_top #(.WARN_CYCLES(WARN), .FLASH_CYCLES(8)) i_dut (.clk,
    .srst, .reader_present, .address_upper_selector(hi),
    .address_lower_selector(lo), .spare_selector_a, .spare_selector_b,
    .err_hw(ev[0]), .err_nvm(ev[1]), .err_intmem(ev[2]),
    .err_fieldbus(ev[3]), .err_script(ev[4]), .warn_rs_tx_ovf(ev[5]),
    .warn_rs_rx_ovf(ev[6]), .warn_rs_timeout(ev[7]),
    .warn_fb_general(ev[8]), .warn_fb_parity(ev[9]),
    .warn_fb_config(ev[10]), .warn_fb_ovf(ev[11]), .fb_state,
    .poll_strobe, .poll_addr, .data_exchange_enable, .station_address,
    .station_address_valid, .module_state_indicator, .code_indicator_bit0,
    .code_indicator_bit1, .code_indicator_bit2, .code_indicator_bit3,
    .ext_diag_byte, .fieldbus_state_indicator, .fieldbus_fault_indicator);
  ////////////////////////////////////////////////////////////////////////
  task complete_run;
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task pulse(input int i);
    ev[i] = 1'b1;
    cyc(1);
    ev[i] = 1'b0;
  endtask : pulse
  task do_reset;
    srst = 1'b1;
    cyc(16);
    srst = 1'b0;
  endtask : do_reset
  // Output watcher: takes the oldest note whenever a result appears
  always @(posedge clk) begin
    // Notes are popped once, before the compare, so a miss eats one note
    if (poll_strobe && pq.size() > 0) begin
      poll_exp = pq.pop_front();
      `CHK(poll_addr, poll_exp)
    end
    if (!srst && ext_diag_byte !== prev_diag) begin
      diag_exp = (evq.size() > 0) ? evq.pop_front() : 10'h3FF;
      `CHK({module_state_indicator, ext_diag_byte}, diag_exp)
      if (module_state_indicator == 2'h2) `CHK(code, ext_diag_byte[3:0])
    end
    prev_diag = srst ? 8'h0 : ext_diag_byte;
    cyc_cnt++;
    if (cyc_cnt > LIMIT) begin
      errors++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h3B43));
    hi = 4'($urandom());
    lo = 4'($urandom());
    misset = 4'($urandom_range(15, 1));
    do_reset;
    cyc(6);
    `CHK(data_exchange_enable, 1'b0)
    misset = 4'h0;
    for (int i = 0; i < 5; i++) begin
      do_reset;
      pulse(5 + i);
      evq.push_back({2'h2, 4'h0, codes[5 + i]});
      cyc(3);
      pulse(i);
      evq.push_back({2'h2, 4'h0, codes[i]});
      cyc(3);
      pulse((i + 1) % 5);
      cyc(4);
      `CHK(ext_diag_byte, {4'h0, codes[i]})
    end
    do_reset;
    pq = '{2'h1, 2'h3, 2'h0};
    cyc(6);
    `CHK(station_address, {hi, lo})
    `CHK(data_exchange_enable, 1'b1)
    hi = ~hi;
    lo = ~lo;
    cyc(6);
    `CHK(station_address, {~hi, ~lo})
    for (int i = 5; i < 12; i++) begin
      pulse(i);
      evq.push_back({2'h2, 4'h0, codes[i]});
      cyc(4);
    end
    evq.push_back({2'h1, 8'h00});
    cyc(WARN - 12);
    `CHK(ext_diag_byte, 8'h0E)
    cyc(20);
    `CHK(evq.size(), 0)
    foreach (fbt[k]) begin
      fb_state = fbt[k][5:4];
      cyc(2);
      seen = 4'h0;
      repeat (20) begin
        seen[fieldbus_state_indicator] = 1'b1;
        cyc(1);
      end
      `CHK(seen, fbt[k][3:0])
      `CHK(fieldbus_fault_indicator, fb_state != 2'h3)
    end
    for (int k = 0; k < 80000 && pq.size() > 0; k++) cyc(1);
    `CHK(pq.size(), 0)
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
